// *** hdl/odsf_device.sv ***
// converter device end: serial front end and eight channel registers
// assumes the host keeps link timing; link logic runs on the link clock
//
// Operation
// - valid frame is sixteen falling clock edges
// - shift serial input on each falling edge
// - host never lowers sync on falling edge
// - execute received command when sync rises
// - host raises sync between edges 16, 17
// - sync rising early aborts, nothing executed; a frame with no falls right after a valid one executes it again
// - from edge 16 on, input passes to output
// - host keeps sync high minimum between frames
// - host idles sync high
// - chains shift multiples of sixteen bits
// - n chained devices need n*16 edges
// - output low 14 edges, high on 15th
// - next sixteen edges echo first input bits
// - every chained device executes on sync rise
// - straight binary code scaled by group reference
// - per channel register, direct or deferred update
// - powered-down channel register still accepts writes
// - recovery delay before powered-up output returns
// - per channel power-down state with three terminations
// - msb first, command, code, four ignored
// - serial output changes on falling edges
// - reset register-only; 1001 through, 1000 back
`timescale 1ns/1ps
module odsf_device
  import odsf_pkg::*;
(
  odsf_if.device link,
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reference_low_group_in,
  input wire logic [7:0] reference_high_group_in,
  output logic [7:0][7:0] level_out,
  output logic [7:0][7:0] code_out,
  output odsf_pd_t [7:0] powerdown_termination_out,
  output logic [7:0] chan_ready_out,
  output logic write_through_mode_out,
  output logic exec_out,
  output logic abort_out
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // scale a code by an 8-bit reference: ref * code / 256
  function automatic logic [7:0] scale(input logic [7:0] ref_v, input logic [7:0] code_v);
    logic [15:0] prod;
    prod = 16'(ref_v) * 16'(code_v);
    return prod[15:8];
  endfunction : scale

  // ****************************************************************
  // link clock domain
  // ****************************************************************
  logic [15:0] shift_q;        // input shift register, newest bit at 0
  logic [4:0] cnt_q;           // falling edges in this frame, saturating
  logic [4:0] cnt_d;           // edge number of the edge now taken
  logic fresh_q;               // next falling edge is the first of a frame
  logic dout_q;                // serial output flop

  // sync high arms a restart, so no edge is needed after the frame ends
  always_ff @(negedge link.sclk or posedge link.sync_n or negedge nrst_in)
  begin
    if (!nrst_in)
      fresh_q <= 1'b1;
    else if (link.sync_n)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // edge number of the current falling edge
  always_comb
  begin
    if (fresh_q)
      cnt_d = 5'h01;
    else if (cnt_q == CNT_MAX)
      cnt_d = cnt_q;  // long chains just saturate
    else
      cnt_d = cnt_q + 5'h01;
  end

  // edge counter, only while the frame is open
  always_ff @(negedge link.sclk or negedge nrst_in)
  begin
    if (!nrst_in)
      cnt_q <= 5'h00;
    else if (!link.sync_n)
      cnt_q <= cnt_d;
  end

  // shift register, msb first so bit 15 ends as the first bit sent
  always_ff @(negedge link.sclk or negedge nrst_in)
  begin
    if (!nrst_in)
      shift_q <= 16'h0000;
    else if (!link.sync_n)
      shift_q <= {shift_q[14:0], link.din};
  end

  // serial output: low, a marker, then the echo of earlier input
  always_ff @(negedge link.sclk or negedge nrst_in)
  begin
    if (!nrst_in)
      dout_q <= 1'b0;
    else if (!link.sync_n)
    begin
      if (cnt_d <= DOUT_LOW_EDGES)
        dout_q <= 1'b0;
      else if (cnt_d == DOUT_MARK_EDGE)
        dout_q <= 1'b1;
      else
        dout_q <= shift_q[14];
    end
  end

  assign link.dout = dout_q;

  // ****************************************************************
  // crossing into the core domain
  // ****************************************************************
  logic sync_n_s;              // frame sync, synchronised
  logic sync_n_old_q;          // previous synchronised value
  logic [7:0] ref_lo_s;        // low group reference, synchronised
  logic [7:0] ref_hi_s;        // high group reference, synchronised
  logic frame_end;             // sync rose, shift register now frozen

  odsf_sync #(.W(1), .RST(1'b1)) u_sync_frame (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in(link.sync_n),
    .q_out(sync_n_s)
  );

  odsf_sync #(.W(16), .RST(16'h0000)) u_sync_ref (
    .clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .d_in({reference_high_group_in, reference_low_group_in}),
    .q_out({ref_hi_s, ref_lo_s})
  );

  // edge detect on the synchronised copy only
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sync_n_old_q <= 1'b1;
    else
      sync_n_old_q <= sync_n_s;
  end

  // shift_q and cnt_q hold still while sync is high, so reading them two
  // flops after the rise is safe; a new frame within that time would race
  assign frame_end = sync_n_s && !sync_n_old_q;

  // ****************************************************************
  // command execution
  // ****************************************************************
  logic [3:0] cmd;             // command field of the frame
  logic [7:0] data;            // code field of the frame
  logic valid;                 // enough edges seen to execute
  logic [7:0][7:0] reg_q;      // channel data registers
  logic [7:0][7:0] act_q;      // codes driving the converters
  logic mode_q;                // 1 = write-through
  odsf_pd_t [7:0] pd_q;        // per channel power-down state
  logic [7:0][6:0] wake_q;     // recovery countdown per channel

  assign cmd = shift_q[ADDR_HI:ADDR_LO];
  assign data = shift_q[DATA_HI:DATA_LO];
  assign valid = (cnt_q >= EXEC_MIN_EDGES);

  // event pulses for the user side
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      exec_out <= 1'b0;
      abort_out <= 1'b0;
    end
    else
    begin
      exec_out <= frame_end && valid;
      abort_out <= frame_end && !valid;
    end
  end

  // operating mode
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mode_q <= MODE_RST;
    else if (frame_end && valid && cmd == CMD_WRITE_THRU)
      mode_q <= 1'b1;
    else if (frame_end && valid && cmd == CMD_REG_ONLY)
      mode_q <= 1'b0;
  end

  // data registers and active codes; writes land even when powered down
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reg_q <= {N_CH{CODE_RST}};
      act_q <= {N_CH{CODE_RST}};
    end
    else if (frame_end && valid)
    begin
      if (!cmd[3])
      begin
        reg_q[cmd[2:0]] <= data;
        if (mode_q)
          act_q[cmd[2:0]] <= data;
      end
      else if (cmd == CMD_UPDATE)
        act_q <= reg_q;
      else if (cmd == CMD_CH1)
      begin
        act_q <= reg_q;
        reg_q[0] <= data;
        act_q[0] <= data;
      end
      else if (cmd == CMD_BCAST)
      begin
        reg_q <= {N_CH{data}};
        act_q <= {N_CH{data}};
      end
    end
  end

  // power-down per channel: set bits take the termination, clear bits wake
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pd_q <= '{default: ODSF_PD_ON};
    else if (frame_end && valid && cmd[3:2] == 2'b11 && cmd[1:0] != 2'b00)
    begin
      for (int i = 0; i < N_CH; i++)
        pd_q[i] <= data[i] ? odsf_pd_t'(cmd[1:0]) : ODSF_PD_ON;
    end
  end

  // recovery countdown, started when a channel leaves power-down
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      wake_q <= '0;
    else
    begin
      for (int i = 0; i < N_CH; i++)
      begin
        if (frame_end && valid && cmd[3:2] == 2'b11 && cmd[1:0] != 2'b00
            && pd_q[i] != ODSF_PD_ON && !data[i])
          wake_q[i] <= WAKE_W'(WAKE_CYC);
        else if (wake_q[i] != 7'h00)
          wake_q[i] <= wake_q[i] - 7'h01;
      end
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      level_out <= '0;
      chan_ready_out <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < N_CH; i++)
      begin
        chan_ready_out[i] <= (pd_q[i] == ODSF_PD_ON) && (wake_q[i] == 7'h00);
        if (pd_q[i] != ODSF_PD_ON || wake_q[i] != 7'h00)
          level_out[i] <= 8'h00;
        else if (i < GROUP_SPLIT)
          level_out[i] <= scale(ref_lo_s, act_q[i]);
        else
          level_out[i] <= scale(ref_hi_s, act_q[i]);
      end
    end
  end

  // copies of state for observation
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      code_out <= '0;
      powerdown_termination_out <= '{default: ODSF_PD_ON};
      write_through_mode_out <= MODE_RST;
    end
    else
    begin
      code_out <= act_q;
      powerdown_termination_out <= pd_q;
      write_through_mode_out <= mode_q;
    end
  end

endmodule : odsf_device

// *** hdl/odsf_host.sv ***
// host serial master end: makes the link clock and sends whole frames
// assumes a user side that holds the frame word steady while busy
`timescale 1ns/1ps
module odsf_host
  import odsf_pkg::*;
(
  odsf_if.host link,
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic [CHAIN_BITS-1:0] frame_in,
  output logic busy_out,
  output logic done_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {
    ODSF_ST_IDLE = 3'b000,   // sync high, link clock high
    ODSF_ST_LEAD = 3'b001,   // sync low, setup before first fall
    ODSF_ST_LOW = 3'b010,    // link clock low half
    ODSF_ST_HIGH = 3'b011,   // link clock high half
    ODSF_ST_GAP = 3'b100     // sync high between frames
  } odsf_hst_t;

  odsf_hst_t st_q;               // current state
  logic [3:0] div_q;             // core cycles left in this half
  logic [7:0] bits_q;            // falling edges still to make
  logic [CHAIN_BITS-1:0] sh_q;   // bits still to send, msb first
  logic sclk_q;                  // link clock flop
  logic sync_n_q;                // frame sync flop
  logic din_q;                   // data flop

  assign link.sclk = sclk_q;
  assign link.sync_n = sync_n_q;
  assign link.din = din_q;

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // data changes when sync falls and on rising edges, so it is stable at each fall
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_q <= ODSF_ST_IDLE;
      div_q <= 4'h0;
      bits_q <= 8'h00;
      sh_q <= '0;
      sclk_q <= 1'b1;
      sync_n_q <= 1'b1;
      din_q <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      unique case (st_q)
        ODSF_ST_IDLE:
        begin
          if (start_in)
          begin
            // sync falls a half period before the first fall
            sync_n_q <= 1'b0;
            din_q <= frame_in[CHAIN_BITS-1];
            sh_q <= {frame_in[CHAIN_BITS-2:0], 1'b0};
            bits_q <= 8'(CHAIN_BITS);
            div_q <= 4'(SCLK_HALF_CYC - 1);
            st_q <= ODSF_ST_LEAD;
          end
        end
        ODSF_ST_LEAD, ODSF_ST_HIGH:
        begin
          if (div_q != 4'h0)
            div_q <= div_q - 4'h1;
          else if (bits_q == 8'h00)
          begin
            // last rising edge done; raise sync before any further fall
            sync_n_q <= 1'b1;
            div_q <= 4'(SYNC_HIGH_CYC - 1);
            st_q <= ODSF_ST_GAP;
          end
          else
          begin
            sclk_q <= 1'b0;
            bits_q <= bits_q - 8'h01;
            div_q <= 4'(SCLK_HALF_CYC - 1);
            st_q <= ODSF_ST_LOW;
          end
        end
        ODSF_ST_LOW:
        begin
          if (div_q != 4'h0)
            div_q <= div_q - 4'h1;
          else
          begin
            sclk_q <= 1'b1;
            din_q <= sh_q[CHAIN_BITS-1];
            sh_q <= {sh_q[CHAIN_BITS-2:0], 1'b0};
            div_q <= 4'(SCLK_HALF_CYC - 1);
            st_q <= ODSF_ST_HIGH;
          end
        end
        ODSF_ST_GAP:
        begin
          if (div_q != 4'h0)
            div_q <= div_q - 4'h1;
          else
          begin
            done_out <= 1'b1;
            st_q <= ODSF_ST_IDLE;
          end
        end
        default:
          st_q <= ODSF_ST_IDLE;  // three codes are unused
      endcase
    end
  end

  // busy rises with the state on start and falls one cycle after the state is idle
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      busy_out <= 1'b0;
    else
      busy_out <= (st_q != ODSF_ST_IDLE) || start_in;
  end

endmodule : odsf_host

// *** hdl/odsf_if.sv ***
// link wires between host serial master and converter device
// assumes the bench joins host and device through one instance of this
`timescale 1ns/1ps
interface odsf_if;
  logic sclk;    // link clock, made by the host
  logic sync_n;  // frame sync, active low
  logic din;     // serial data toward the device
  logic dout;    // serial data out of the device, for chaining

  modport host (output sclk, output sync_n, output din, input dout);
  modport device (input sclk, input sync_n, input din, output dout);
endinterface : odsf_if

// *** hdl/odsf_pkg.sv ***
// constants and types shared by both ends of the octal converter serial link
// assumes a 10 MHz core clock on each end and a link clock made by the host
package odsf_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 16;            // bits in one device frame
  localparam int ADDR_HI = 15;               // command field, top bit
  localparam int ADDR_LO = 12;               // command field, low bit
  localparam int DATA_HI = 11;               // code field, top bit
  localparam int DATA_LO = 4;                // code field, low bit
  localparam int CNT_W = 5;                  // falling edge counter width
  localparam logic [4:0] CNT_MAX = 5'h1F;    // counter saturates here
  localparam logic [4:0] DOUT_LOW_EDGES = 5'h0E;  // serial out low up to here
  localparam logic [4:0] DOUT_MARK_EDGE = 5'h0F;  // serial out goes high here
  localparam logic [4:0] EXEC_MIN_EDGES = 5'h10;  // edges needed to execute

  // ****************************************************************
  // channels and commands
  // ****************************************************************
  localparam int N_CH = 8;                   // channel count
  localparam int CODE_W = 8;                 // converter code width
  localparam int GROUP_SPLIT = 4;            // channels below use low group ref
  localparam logic [3:0] CMD_REG_ONLY = 4'h8;    // select register-only mode
  localparam logic [3:0] CMD_WRITE_THRU = 4'h9;  // select write-through mode
  localparam logic [3:0] CMD_UPDATE = 4'hA;      // copy all registers to outputs
  localparam logic [3:0] CMD_CH1 = 4'hB;         // write channel 1, update all
  localparam logic [3:0] CMD_BCAST = 4'hC;       // write all channels at once
  localparam logic MODE_RST = 1'b0;              // register-only after reset
  localparam logic [7:0] CODE_RST = 8'h00;       // code zero after reset

  // power-down state; low two bits of commands D..F map straight onto it
  typedef enum logic [1:0] {
    ODSF_PD_ON = 2'b00,
    ODSF_PD_HIZ = 2'b01,
    ODSF_PD_100K = 2'b10,
    ODSF_PD_2K5 = 2'b11
  } odsf_pd_t;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CORE_PERIOD_NS = 100;       // core clock period
  localparam int WAKE_NS = 8000;             // output recovery after power-up
  localparam int WAKE_CYC = (WAKE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int WAKE_W = 7;                 // holds WAKE_CYC
  localparam int SYNC_HIGH_NS = 5;           // least frame sync high time
  localparam int SYNC_HIGH_RAW = (SYNC_HIGH_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_RAW < 1) ? 1 : SYNC_HIGH_RAW;
  localparam int SCLK_HALF_CYC = 2;          // core cycles per link clock half
  localparam int CHAIN_DEVS = 1;             // devices in the chain
  localparam int CHAIN_BITS = CHAIN_DEVS * FRAME_BITS;

endpackage : odsf_pkg

// *** hdl/odsf_sync.sv ***
// two flip-flop synchroniser for quasi-static levels
// assumes multi-bit inputs change rarely and are not sampled mid-change
`timescale 1ns/1ps
module odsf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q; // first stage, read only by the second

  // ****************************************************************
  // two stages
  // ****************************************************************
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_q <= RST;
      q_out <= RST;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule : odsf_sync

// *** verif/octal_dac_serial_frontend_bench.sv ***
// bench: host and device on one link; a second device on a link driven here
// assumes 10 MHz core clock; the second link clock is made here at 125 ns
`timescale 1ns/1ps
module octal_dac_serial_frontend_bench;
  import odsf_pkg::*;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b1; // lowered just after time zero so link flops see an edge
  logic start_in = 1'b0;
  logic [CHAIN_BITS-1:0] frame_in = '0;
  logic [7:0] ref_lo = 8'h00; // low group reference
  logic [7:0] ref_hi = 8'h00; // high group reference
  logic busy_out, done_out, wt_out, exec_out, abort_out, exec2_out, abort2_out;
  logic [7:0][7:0] level_out, code_out, code2_out;
  odsf_pd_t [7:0] pd_out;
  logic [7:0] ready_out;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_exec2 = 0;
  int n_abort2 = 0;
  int n_exec1 = 0;
  int n_abort1 = 0;
  logic [7:0] regs [8]; // expected channel registers
  logic [7:0] act [8]; // expected active codes
  logic [1:0] pd [8]; // expected power-down states
  logic mode = 1'b0;
  logic wk [8]; // expected channels still in power-up recovery

  odsf_if u_odsf_if ();
  odsf_if u_odsf_if_2 (); // second link, driven by the bench to break rules
  odsf_host u_odsf_host (.link(u_odsf_if), .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .start_in(start_in), .frame_in(frame_in), .busy_out(busy_out), .done_out(done_out));
  odsf_device u_odsf_device (.link(u_odsf_if), .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .reference_low_group_in(ref_lo), .reference_high_group_in(ref_hi),
    .level_out(level_out), .code_out(code_out), .powerdown_termination_out(pd_out),
    .chan_ready_out(ready_out), .write_through_mode_out(wt_out),
    .exec_out(exec_out), .abort_out(abort_out));
  odsf_device u_odsf_device_2 (.link(u_odsf_if_2), .core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .reference_low_group_in(ref_lo), .reference_high_group_in(ref_hi),
    .level_out(), .code_out(code2_out), .powerdown_termination_out(),
    .chan_ready_out(), .write_through_mode_out(),
    .exec_out(exec2_out), .abort_out(abort2_out));
  odsf_link_chk u_odsf_link_chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .sclk(u_odsf_if.sclk), .sync_n(u_odsf_if.sync_n), .din(u_odsf_if.din),
    .dout(u_odsf_if.dout));

  always #50 core_clk_in = ~core_clk_in;

  // pulse counters for both devices and the hang limit
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (exec2_out === 1'b1) n_exec2++;
    if (exec_out === 1'b1) n_exec1++;
    if (abort_out === 1'b1) n_abort1++;
    if (abort2_out === 1'b1) n_abort2++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("[ERR] %0t run too long", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // expected vector: 0 codes, 1 levels, 2 power-down, 3 ready
  function automatic logic [63:0] exp_vec(input int sel);
    logic [15:0] p;
    exp_vec = '0;
    for (int i = 0; i < N_CH; i++)
    begin
      p = {8'h00, (i < GROUP_SPLIT) ? ref_lo : ref_hi} * {8'h00, act[i]};
      case (sel)
        0: exp_vec[8*i +: 8] = act[i];
        1: exp_vec[8*i +: 8] = (pd[i] == 2'b00 && !wk[i]) ? p[15:8] : 8'h00;
        2: exp_vec[2*i +: 2] = pd[i];
        default: exp_vec[i] = (pd[i] == 2'b00) && !wk[i];
      endcase
    end
  endfunction : exp_vec

  // model of one executed frame; low nibble is never looked at
  function automatic void apply(input logic [15:0] f);
    logic [3:0] c;
    logic [7:0] d;
    c = f[15:12];
    d = f[11:4];
    if (c == CMD_REG_ONLY) mode = 1'b0;
    if (c == CMD_WRITE_THRU) mode = 1'b1;
    for (int i = 0; i < N_CH; i++)
    begin
      if (!c[3] && c[2:0] == i[2:0])
      begin
        regs[i] = d;
        if (mode) act[i] = d;
      end
      if ((c == CMD_CH1 && i == 0) || c == CMD_BCAST) regs[i] = d;
      if (c == CMD_UPDATE || c == CMD_CH1 || c == CMD_BCAST) act[i] = regs[i];
      // recovery of WAKE_CYC ends before the next frame is checked
      wk[i] = (c > CMD_BCAST) && (pd[i] != 2'b00) && !d[i];
      if (c > CMD_BCAST) pd[i] = d[i] ? c[1:0] : 2'b00;
    end
  endfunction : apply

  task automatic check_all(input bit lvl);
    chk(code_out, exp_vec(0));
    chk(64'(wt_out), 64'(mode));
    chk(64'(pd_out), exp_vec(2));
    if (lvl) chk(level_out, exp_vec(1));
  endtask : check_all

  // one frame through the host, then compare once the device has executed
  task automatic send(input logic [15:0] f);
    int n;
    n = 0;
    frame_in = f;
    start_in = 1'b1;
    @(negedge core_clk_in);
    start_in = 1'b0;
    chk(64'(busy_out), 64'h1);
    while (done_out !== 1'b1 && n < 200)
    begin
      @(negedge core_clk_in);
      n++;
    end
    chk(64'(done_out), 64'h1);
    repeat (8) @(negedge core_clk_in);
    apply(f);
    check_all(1'b1);
    chk(64'(busy_out), 64'h0);
  endtask : send

  // n link falls on the second link; serial out checked after each fall
  task automatic drive2(input int n, input logic [31:0] w);
    logic e;
    u_odsf_if_2.sync_n = 1'b0;
    for (int k = 1; k <= n; k++)
    begin
      u_odsf_if_2.din = w[n-k];
      #62.5 u_odsf_if_2.sclk = 1'b0;
      e = (k < 15) ? 1'b0 : (k == 15) ? 1'b1 : w[n+15-k];
      #10 chk(64'(u_odsf_if_2.dout), 64'(e));
      #52.5 u_odsf_if_2.sclk = 1'b1;
    end
    #62.5 u_odsf_if_2.sync_n = 1'b1;
    u_odsf_if_2.din = ~u_odsf_if_2.din; // released line does not keep its value
    repeat (10) @(negedge core_clk_in);
  endtask : drive2

  initial
  begin
    #1 nrst_in = 1'b0; // a real falling edge clears the link-clocked flops
    void'($urandom(83077));
    ref_lo = 8'($urandom);
    ref_hi = 8'($urandom);
    u_odsf_if_2.sclk = 1'b1;
    u_odsf_if_2.sync_n = 1'b1;
    u_odsf_if_2.din = 1'b0;
    for (int i = 0; i < N_CH; i++)
    begin
      regs[i] = 8'h00;
      act[i] = 8'h00;
      pd[i] = 2'b00;
      wk[i] = 1'b0;
    end
    repeat (4) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge core_clk_in);
    check_all(1'b1);
    // every command below power-down, then boundary codes, then random frames
    for (int c = 0; c < 13; c++) send({c[3:0], 8'($urandom), 4'($urandom)});
    send({CMD_WRITE_THRU, 12'h000});
    send({4'h3, 8'hFF, 4'hF});
    send({CMD_REG_ONLY, 12'h000});
    send({4'h5, 8'h00, 4'h0});
    repeat (40) send({4'($urandom % 13), 8'($urandom), 4'($urandom)});
    // power-down, write while down, wake with recovery delay
    send({4'hD, 8'h81, 4'h0});
    chk(ready_out, exp_vec(3));
    send({4'hE, 8'h02, 4'h0});
    chk(ready_out, 8'h7C);
    send({4'h1, 8'h5A, 4'h0});
    send({4'hF, 8'h00, 4'h0});
    send({CMD_UPDATE, 12'h000});
    repeat (100) @(negedge core_clk_in);
    check_all(1'b1);
    chk(ready_out, 8'hFF);
    // short frames on the second link are dropped
    drive2(8, 32'h0000000A);
    drive2(15, 32'h00000558);
    chk(64'(n_abort2), 64'h2);
    chk(code2_out, 64'h0);
    // a 32-fall chain frame: first half passes out, last half executes
    drive2(32, {16'($urandom), CMD_BCAST, 8'h3C, 4'h0});
    chk(64'(n_exec2), 64'h1);
    chk(code2_out, {8{8'h3C}});
    chk(64'(n_exec1), 64'h3E);
    chk(64'(n_abort1), 64'h0);
    end_of_test();
  end
endmodule : octal_dac_serial_frontend_bench

// *** verif/odsf_link_chk.sv ***
// link checker: frame shape and serial output timing on the host-device link
// assumes the host makes sclk from core_clk_in, so core edges see every link edge
`timescale 1ns/1ps
module odsf_link_chk (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic dout
);
  logic [4:0] falls_q; // link falls seen so far in this frame

  // count falls on the core clock; cleared at each frame start
  always_ff @(posedge core_clk_in or negedge nrst_in)
    if (!nrst_in)
      falls_q <= 5'h00;
    else if ($fell(sync_n))
      falls_q <= 5'h00;
    else if (!sync_n && $fell(sclk))
      falls_q <= falls_q + 5'h01;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // a fall inside a frame that is the k-th plus one
  sequence s_fall_after(logic [4:0] k);
    !sync_n && $fell(sclk) && falls_q == k;
  endsequence
  // sclk stays high long enough after sync falls
  sequence s_setup;
    sclk ##1 sclk ##1 !sclk;
  endsequence

  property p_len;
    $rose(sync_n) |-> falls_q == 5'h10;
  endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_low;
    !sync_n && $fell(sclk) && falls_q < 5'h0E |-> !dout;
  endproperty
  a_low: assert property (p_low) else $error("serial out not low");
  property p_mark;
    s_fall_after(5'h0E) |-> dout;
  endproperty
  a_mark: assert property (p_mark) else $error("serial out mark missing");
  property p_hold;
    $changed(dout) |-> !sync_n && $fell(sclk);
  endproperty
  a_hold: assert property (p_hold) else $error("serial out moved off a fall");
  property p_din;
    !sync_n && !$past(sync_n) && $changed(din) |-> $rose(sclk);
  endproperty
  a_din: assert property (p_din) else $error("data moved near a fall");
  property p_idle;
    sync_n |-> sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("clock low while idle");
  property p_setup;
    $fell(sync_n) |-> s_setup;
  endproperty
  a_setup: assert property (p_setup) else $error("sync fell near a fall");
  property p_gap;
    $rose(sync_n) |-> sync_n [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("sync high gap short");
endmodule : odsf_link_chk
